// ===== logic/hsm_pkg.sv
`default_nettype none
package hsm_pkg;
  // Arbitrary bus address for the monitor
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // Command byte fields
  localparam int CMD_VFREE = 0;
  localparam int CMD_VONCE = 1;
  localparam int CMD_IFREE = 2;
  localparam int CMD_IONCE = 3;
  localparam int CMD_DIV = 4;
  localparam int CMD_STATRD = 6;
  localparam logic [6:0] CMD_RST = 7'h00;

  // Extended register pointers
  localparam logic [1:0] EXT_MASK = 2'h1;
  localparam logic [1:0] EXT_THRESH = 2'h2;
  localparam logic [1:0] EXT_CTRL = 2'h3;

  // Alert mask fields and resets
  localparam int MSK_OC1 = 0;
  localparam int MSK_OC4 = 1;
  localparam int MSK_FAULT = 2;
  localparam int MSK_OFF = 3;
  localparam int MSK_CLR = 4;
  localparam logic [7:0] MASK_RST = 8'h04;
  localparam logic [7:0] THRESH_RST = 8'hFF;
  localparam int CTRL_SOFT_OFF = 0;

  // Status byte fields
  localparam int ST_OC_NOW = 0;
  localparam int ST_ADC_ALERT = 1;
  localparam int ST_TRIP = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_OFF = 4;
  localparam int ST_OFF_ALERT = 5;

  // Bus timing of the controller end
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_QTR_NS = 700;
  localparam int QTR_CYCLES = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] QTR_LAST = 3'(QTR_CYCLES - 1);

  // Controller register map (byte addresses)
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
  localparam logic [7:0] HOST_STAT_OFS = 8'h08;
  localparam logic [7:0] HOST_RDATA_OFS = 8'h0C;
  localparam int HC_GO = 0;
  localparam int HC_READ = 1;
  localparam int HC_CNT = 2;
  localparam int HC_ACKLAST = 4;
  localparam int HS_BUSY = 0;
  localparam int HS_NACK = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ACK_ADDR, SL_WRITE, SL_ACK_WR, SL_READ, SL_ACK_RD
  } hsm_slv_state_t;

  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BIT, MS_STOP
  } hsm_mst_state_t;
endpackage
`default_nettype wire

// ===== logic/hsm_if.sv
`default_nettype none
interface hsm_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain resolution with pull-ups
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
               (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host(input scl, input sda, output host_scl_o,
               output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ===== logic/hsm_sync.sv
`default_nettype none
module hsm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule
`default_nettype wire

// ===== logic/hsm_device.sv
// Behaviour
// [R1] Soft disable bit switches the output off
// [R2] Readback: both, voltage only, current only
// [R3] Both: V high, I high, nibbles
// [R4] Voltage only: V high, V low nibble
// [R5] Current only: I high, I low nibble
// [R6] Read: address, ack, master nacks last
// [R7] Master stops after two bytes single-channel
// [R8] Voltage code scaled by range over 4096
// [R9] Current code scaled, divided by sense resistance
// [R10] Status read returns one status byte
// [R11] Status bit0: last three samples overcurrent
// [R12] Status bit1: sampled overcurrent alert latched
// [R13] Status bit2: analog trip state per variant
// [R14] Status bit3: failed attempt latched
// [R15] Status bit4: pin off or soft disable
// [R16] Status bit5: off alert latched
// [R17] Clear bit resets status bits 1,3,5
// [R18] Retry and latch-off build variants
// [R19] Status select returns status byte
// [R20] Clear bit self-clears; flags may re-set
// [R21] Single-shot: nack reads until done
// [R22] Free-run before first result reads zeros
// [R23] Soft disable holds until written zero
`default_nettype none
module hsm_device #(
  parameter bit LATCH_OFF = 1'b1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  hsm_if.dev bus,
  input wire logic on_pin_in,
  input wire logic analog_trip_in,
  input wire logic volt_done_in,
  input wire logic [11:0] volt_code_in,
  input wire logic curr_done_in,
  input wire logic [11:0] curr_code_in,
  output logic volt_conv_out,
  output logic curr_conv_out,
  output logic divider_select_out,
  output logic switch_on_out
);
  hsm_pkg::hsm_slv_state_t state_ff;
  logic [3:0] sync_q;
  logic scl_s, sda_s, on_s, trip_s;
  logic scl_d_ff, sda_d_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [2:0] cnt_ff;
  logic [7:0] shift_ff;
  logic rx_full_ff, oe_ff, rw_ff, ack_ff, ext_pend_ff;
  logic [1:0] idx_ff, tx_idx, ptr_ff;
  logic cmd_wr_ff, ext_wr_ff;
  logic [7:0] wdata_ff;
  logic [6:0] cmd_ff;
  logic [7:0] mask_ff, thresh_ff;
  logic soft_disable_ff;
  logic [11:0] volt_ff, curr_ff;
  logic once_pending, v_sel, i_sel;
  logic [3:0] oc_hist_ff;
  logic oc_evt_ff, adc_alert_ff, switch_fault_flag_ff;
  logic trip_d_ff, trip_latch_ff, off_d_ff, off_alert_ff, switch_on_ff;
  logic off_now, analog_trip_state, sampled_overcurrent_now, clear_req;
  logic [7:0] status_byte, tx_byte;

  hsm_sync #(.W(4), .RST_VAL(4'hC)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({bus.scl, bus.sda, on_pin_in, analog_trip_in}),
    .q_out(sync_q)
  );
  assign {scl_s, sda_s, on_s, trip_s} = sync_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  assign once_pending = cmd_ff[hsm_pkg::CMD_VONCE] | cmd_ff[hsm_pkg::CMD_IONCE];
  assign v_sel = cmd_ff[hsm_pkg::CMD_VFREE] | cmd_ff[hsm_pkg::CMD_VONCE];
  assign i_sel = cmd_ff[hsm_pkg::CMD_IFREE] | cmd_ff[hsm_pkg::CMD_IONCE];
  assign tx_idx = (state_ff == hsm_pkg::SL_ACK_RD) ? idx_ff + 2'h1 : idx_ff;

  // Readback byte for the current position in the read
  always_comb begin
    tx_byte = 8'h00;
    if (cmd_ff[hsm_pkg::CMD_STATRD]) begin
      tx_byte = status_byte; // see [R19] [R10]
    end else if (v_sel && !i_sel) begin
      if (tx_idx == 2'h0) tx_byte = volt_ff[11:4]; // see [R4] [R2]
      else if (tx_idx == 2'h1) tx_byte = {volt_ff[3:0], 4'h0}; // see [R4]
    end else if (i_sel && !v_sel) begin
      if (tx_idx == 2'h0) tx_byte = curr_ff[11:4]; // see [R5] [R2]
      else if (tx_idx == 2'h1) tx_byte = {curr_ff[3:0], 4'h0}; // see [R5]
    end else begin
      if (tx_idx == 2'h0) tx_byte = volt_ff[11:4]; // see [R3] [R2]
      else if (tx_idx == 2'h1) tx_byte = curr_ff[11:4]; // see [R3]
      else if (tx_idx == 2'h2) tx_byte = {volt_ff[3:0], curr_ff[3:0]};
    end
  end

  // Serial slave engine
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= hsm_pkg::SL_IDLE;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      rx_full_ff <= 1'b0;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      idx_ff <= 2'h0;
      ext_pend_ff <= 1'b0;
      ptr_ff <= 2'h0;
      cmd_wr_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      cmd_wr_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      if (start_cond) begin
        state_ff <= hsm_pkg::SL_ADDR;
        cnt_ff <= 3'h0;
        rx_full_ff <= 1'b0;
        oe_ff <= 1'b0;
        idx_ff <= 2'h0;
        ext_pend_ff <= 1'b0;
      end else if (stop_cond) begin
        state_ff <= hsm_pkg::SL_IDLE;
        oe_ff <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_ff)
          hsm_pkg::SL_ADDR, hsm_pkg::SL_WRITE: begin
            shift_ff <= {shift_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 3'h1;
            rx_full_ff <= (cnt_ff == 3'h7);
          end
          hsm_pkg::SL_ACK_RD: ack_ff <= ~sda_s; // see [R6]
          hsm_pkg::SL_IDLE, hsm_pkg::SL_ACK_ADDR, hsm_pkg::SL_ACK_WR,
          hsm_pkg::SL_READ: ;
        endcase
      end else if (scl_fall) begin
        unique case (state_ff)
          hsm_pkg::SL_ADDR: if (rx_full_ff) begin
            rx_full_ff <= 1'b0;
            if (shift_ff[7:1] == hsm_pkg::DEV_ADDR &&
                !(shift_ff[0] && once_pending)) begin // see [R21]
              oe_ff <= 1'b1; // see [R6]
              rw_ff <= shift_ff[0];
              state_ff <= hsm_pkg::SL_ACK_ADDR;
            end else begin
              state_ff <= hsm_pkg::SL_IDLE;
            end
          end
          hsm_pkg::SL_ACK_ADDR: if (rw_ff) begin
            oe_ff <= ~tx_byte[7];
            shift_ff <= {tx_byte[6:0], 1'b0};
            cnt_ff <= 3'h1;
            state_ff <= hsm_pkg::SL_READ;
          end else begin
            oe_ff <= 1'b0;
            state_ff <= hsm_pkg::SL_WRITE;
          end
          hsm_pkg::SL_WRITE: if (rx_full_ff) begin
            rx_full_ff <= 1'b0;
            oe_ff <= 1'b1;
            wdata_ff <= shift_ff;
            state_ff <= hsm_pkg::SL_ACK_WR;
            if (ext_pend_ff) begin
              ext_wr_ff <= 1'b1;
              ext_pend_ff <= 1'b0;
            end else if (shift_ff[7]) begin
              ext_pend_ff <= 1'b1;
              ptr_ff <= shift_ff[1:0];
            end else begin
              cmd_wr_ff <= 1'b1;
            end
          end
          hsm_pkg::SL_ACK_WR: begin
            oe_ff <= 1'b0;
            state_ff <= hsm_pkg::SL_WRITE;
          end
          hsm_pkg::SL_READ: if (cnt_ff == 3'h0) begin
            oe_ff <= 1'b0;
            state_ff <= hsm_pkg::SL_ACK_RD;
          end else begin
            oe_ff <= ~shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 3'h1;
          end
          // A status read is one byte; driving on would block the stop
          hsm_pkg::SL_ACK_RD: if (ack_ff &&
              !cmd_ff[hsm_pkg::CMD_STATRD]) begin // see [R6] [R7] [R10]
            idx_ff <= idx_ff + 2'h1;
            oe_ff <= ~tx_byte[7];
            shift_ff <= {tx_byte[6:0], 1'b0};
            cnt_ff <= 3'h1;
            state_ff <= hsm_pkg::SL_READ;
          end else begin
            state_ff <= hsm_pkg::SL_IDLE;
          end
          hsm_pkg::SL_IDLE: ;
        endcase
      end
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_ff;

  // Command, mask, threshold and control registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_ff <= hsm_pkg::CMD_RST;
      mask_ff <= hsm_pkg::MASK_RST;
      thresh_ff <= hsm_pkg::THRESH_RST;
      soft_disable_ff <= 1'b0;
    end else begin
      if (cmd_wr_ff) begin
        cmd_ff <= wdata_ff[6:0];
      end else begin
        if (volt_done_in) cmd_ff[hsm_pkg::CMD_VONCE] <= 1'b0; // see [R21]
        if (curr_done_in) cmd_ff[hsm_pkg::CMD_IONCE] <= 1'b0; // see [R21]
      end
      if (ext_wr_ff && ptr_ff == hsm_pkg::EXT_MASK) begin
        mask_ff <= wdata_ff;
      end else if (mask_ff[hsm_pkg::MSK_CLR]) begin
        mask_ff[hsm_pkg::MSK_CLR] <= 1'b0; // see [R20]
      end
      if (ext_wr_ff && ptr_ff == hsm_pkg::EXT_THRESH) thresh_ff <= wdata_ff;
      if (ext_wr_ff && ptr_ff == hsm_pkg::EXT_CTRL) begin
        soft_disable_ff <= wdata_ff[hsm_pkg::CTRL_SOFT_OFF]; // see [R23]
      end
    end
  end

  // Conversion results; a new command restarts from zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      volt_ff <= 12'h000;
      curr_ff <= 12'h000;
    end else if (cmd_wr_ff) begin
      volt_ff <= 12'h000; // see [R22]
      curr_ff <= 12'h000; // see [R22]
    end else begin
      if (volt_done_in) volt_ff <= volt_code_in;
      if (curr_done_in) curr_ff <= curr_code_in;
    end
  end

  assign clear_req = mask_ff[hsm_pkg::MSK_CLR];
  assign off_now = ~on_s | soft_disable_ff; // see [R1] [R15]
  assign analog_trip_state = LATCH_OFF ? trip_latch_ff : trip_s; // see [R13] [R18]
  assign sampled_overcurrent_now = &oc_hist_ff[2:0]; // see [R11]

  // Alert flags; a set in the clearing cycle wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      oc_hist_ff <= 4'h0;
      oc_evt_ff <= 1'b0;
      adc_alert_ff <= 1'b0;
      switch_fault_flag_ff <= 1'b0;
      trip_d_ff <= 1'b0;
      trip_latch_ff <= 1'b0;
      off_d_ff <= 1'b1;
      off_alert_ff <= 1'b0;
      switch_on_ff <= 1'b0;
    end else begin
      oc_evt_ff <= curr_done_in;
      if (curr_done_in) begin
        oc_hist_ff <= {oc_hist_ff[2:0], curr_code_in[11:4] > thresh_ff};
      end
      if (oc_evt_ff && ((mask_ff[hsm_pkg::MSK_OC1] && oc_hist_ff[0]) ||
          (mask_ff[hsm_pkg::MSK_OC4] && &oc_hist_ff))) begin
        adc_alert_ff <= 1'b1; // see [R12]
      end else if (clear_req) begin
        adc_alert_ff <= 1'b0; // see [R17]
      end
      trip_d_ff <= trip_s;
      if (trip_s && !trip_d_ff) trip_latch_ff <= 1'b1; // see [R18]
      else if (off_now) trip_latch_ff <= 1'b0;
      if (trip_s && !trip_d_ff && mask_ff[hsm_pkg::MSK_FAULT]) begin
        switch_fault_flag_ff <= 1'b1; // see [R14]
      end else if (clear_req) begin
        switch_fault_flag_ff <= 1'b0; // see [R17]
      end
      off_d_ff <= off_now;
      if (off_now && !off_d_ff && mask_ff[hsm_pkg::MSK_OFF]) begin
        off_alert_ff <= 1'b1; // see [R16]
      end else if (clear_req) begin
        off_alert_ff <= 1'b0; // see [R17]
      end
      switch_on_ff <= ~off_now & ~(LATCH_OFF & trip_latch_ff); // see [R1] [R23]
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[hsm_pkg::ST_OC_NOW] = sampled_overcurrent_now;
    status_byte[hsm_pkg::ST_ADC_ALERT] = adc_alert_ff;
    status_byte[hsm_pkg::ST_TRIP] = analog_trip_state;
    status_byte[hsm_pkg::ST_FAULT] = switch_fault_flag_ff;
    status_byte[hsm_pkg::ST_OFF] = off_now;
    status_byte[hsm_pkg::ST_OFF_ALERT] = off_alert_ff;
  end

  assign volt_conv_out = v_sel;
  assign curr_conv_out = i_sel;
  assign divider_select_out = cmd_ff[hsm_pkg::CMD_DIV];
  assign switch_on_out = switch_on_ff;
endmodule
`default_nettype wire

// ===== logic/hsm_host.sv
`default_nettype none
module hsm_host (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  hsm_if.host bus,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  hsm_pkg::hsm_mst_state_t state_ff;
  logic [1:0] sync_q;
  logic sda_s;
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wd_ff, rdata_ff;
  logic [3:0] ws_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_wr, go, busy;
  logic rd_mode_ff, acklast_ff, nack_ff;
  logic [1:0] count_ff, byte_ff, phase_ff;
  logic [15:0] wbytes_ff;
  logic [23:0] rx_ff;
  logic [2:0] div_ff;
  logic [3:0] bitn_ff;
  logic tick, is_tx, is_last;
  logic [7:0] tx_byte, tx_sh;
  logic nxt_scl_oe, nxt_sda_oe, scl_oe_ff, sda_oe_ff;

  hsm_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({bus.sda, bus.scl}),
    .q_out(sync_q)
  );
  assign sda_s = sync_q[1];

  assign busy = (state_ff != hsm_pkg::MS_IDLE);
  assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign go = do_wr & (awaddr_ff == hsm_pkg::HOST_CMD_OFS) & ws_ff[0] &
              wd_ff[hsm_pkg::HC_GO] & ~busy;

  // Register slave: write side
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bresp_ff <= hsm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_ff <= 1'b1;
        wd_ff <= s_axi_wdata_in;
        ws_ff <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff == hsm_pkg::HOST_CMD_OFS ||
                     awaddr_ff == hsm_pkg::HOST_WDATA_OFS) ?
                    hsm_pkg::RESP_OKAY : hsm_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Transfer setup, frozen while a transfer runs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_mode_ff <= 1'b0;
      acklast_ff <= 1'b0;
      count_ff <= 2'h0;
      wbytes_ff <= 16'h0000;
    end else if (do_wr && !busy) begin
      if (awaddr_ff == hsm_pkg::HOST_CMD_OFS && ws_ff[0]) begin
        rd_mode_ff <= wd_ff[hsm_pkg::HC_READ];
        count_ff <= wd_ff[hsm_pkg::HC_CNT +: 2];
        acklast_ff <= wd_ff[hsm_pkg::HC_ACKLAST];
      end
      if (awaddr_ff == hsm_pkg::HOST_WDATA_OFS) begin
        if (ws_ff[0]) wbytes_ff[7:0] <= wd_ff[7:0];
        if (ws_ff[1]) wbytes_ff[15:8] <= wd_ff[15:8];
      end
    end
  end

  // Register slave: read side
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= hsm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= hsm_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      unique case (s_axi_araddr_in)
        hsm_pkg::HOST_CMD_OFS: rdata_ff <= {27'h0, acklast_ff, count_ff,
                                            rd_mode_ff, 1'b0};
        hsm_pkg::HOST_WDATA_OFS: rdata_ff <= {16'h0000, wbytes_ff};
        hsm_pkg::HOST_STAT_OFS: rdata_ff <= {30'h0, nack_ff, busy};
        hsm_pkg::HOST_RDATA_OFS: rdata_ff <= {8'h00, rx_ff};
        default: rresp_ff <= hsm_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready_out = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready_out = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = ~rvalid_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  // Bus clock quarter-period divider
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || div_ff == hsm_pkg::QTR_LAST) div_ff <= 3'h0;
    else div_ff <= div_ff + 3'h1;
  end
  assign tick = (div_ff == hsm_pkg::QTR_LAST);

  assign is_tx = (byte_ff == 2'h0) | ~rd_mode_ff;
  assign is_last = (byte_ff == count_ff);
  assign tx_byte = (byte_ff == 2'h0) ? {hsm_pkg::DEV_ADDR, rd_mode_ff} :
                   (byte_ff == 2'h1) ? wbytes_ff[7:0] : wbytes_ff[15:8];
  assign tx_sh = tx_byte << bitn_ff[2:0];

  // Bus controller sequencer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= hsm_pkg::MS_IDLE;
      phase_ff <= 2'h0;
      bitn_ff <= 4'h0;
      byte_ff <= 2'h0;
      nack_ff <= 1'b0;
      rx_ff <= 24'h000000;
    end else if (go) begin
      state_ff <= hsm_pkg::MS_START;
      phase_ff <= 2'h0;
      bitn_ff <= 4'h0;
      byte_ff <= 2'h0;
      nack_ff <= 1'b0;
      rx_ff <= 24'h000000;
    end else if (tick && busy) begin
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3) begin
        unique case (state_ff)
          hsm_pkg::MS_START: state_ff <= hsm_pkg::MS_BIT;
          hsm_pkg::MS_STOP: state_ff <= hsm_pkg::MS_IDLE;
          hsm_pkg::MS_BIT: begin
            if (bitn_ff != 4'h8) begin
              if (!is_tx) rx_ff <= {rx_ff[22:0], sda_s};
              bitn_ff <= bitn_ff + 4'h1;
            end else if (is_tx && sda_s) begin
              nack_ff <= 1'b1;
              state_ff <= hsm_pkg::MS_STOP;
            end else begin
              bitn_ff <= 4'h0;
              byte_ff <= byte_ff + 2'h1;
              if (is_last) state_ff <= hsm_pkg::MS_STOP; // see [R7]
            end
          end
          hsm_pkg::MS_IDLE: ;
        endcase
      end
    end
  end

  // Pin levels for the present phase
  always_comb begin
    nxt_scl_oe = 1'b0;
    nxt_sda_oe = 1'b0;
    unique case (state_ff)
      hsm_pkg::MS_IDLE: ;
      hsm_pkg::MS_START: begin
        nxt_scl_oe = (phase_ff == 2'h3);
        nxt_sda_oe = (phase_ff != 2'h0);
      end
      hsm_pkg::MS_BIT: begin
        nxt_scl_oe = ~phase_ff[1];
        if (bitn_ff != 4'h8) nxt_sda_oe = is_tx & ~tx_sh[7];
        else if (!is_tx) nxt_sda_oe = ~is_last | acklast_ff; // see [R6] [R10]
      end
      hsm_pkg::MS_STOP: begin
        nxt_scl_oe = ~phase_ff[1];
        nxt_sda_oe = (phase_ff != 2'h3);
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_ff;
  assign bus.host_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// ===== dv/hsm_sva.sv
`default_nettype none
module hsm_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic host_scl_in,
  input wire logic host_scl_oe_in,
  input wire logic host_sda_in,
  input wire logic host_sda_oe_in,
  input wire logic dev_sda_in,
  input wire logic dev_sda_oe_in,
  input wire logic scl_in,
  input wire logic sda_in
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_REL_IDLE: assert property ($fell(sys_rst_in) |->
    !host_scl_oe_in && !host_sda_oe_in && !dev_sda_oe_in)
    else $error("bus held");
  AST_START_HOLD: assert property (
    $rose(host_sda_oe_in) && scl_in |-> ##[13:15] !scl_in)
    else $error("start hold wrong");
  AST_STOP_FREE: assert property (
    $fell(host_sda_oe_in) && scl_in |-> sda_in)
    else $error("sda held at stop");
  AST_OPEN_DRAIN: assert property (!host_scl_in && !host_sda_in &&
    !dev_sda_in) else $error("pin driven high");
  AST_DEV_SDA_LOW: assert property (
    $changed(dev_sda_oe_in) |-> !scl_in)
    else $error("slave sda moved in scl high");
  AST_SCL_HI: assert property ($rose(scl_in) |-> scl_in [*8])
    else $error("scl high too short");
  AST_SCL_LO: assert property ($fell(scl_in) |-> !scl_in [*8])
    else $error("scl low too short");
  AST_SCL_LO_MAX: assert property (
    $fell(scl_in) |-> ##[13:22] scl_in)
    else $error("scl low too long");
endmodule
`default_nettype wire

// ===== dv/hot_swap_monitor_readback_tb_top.sv
`default_nettype none
module hot_swap_monitor_readback_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, sys_rst_in = 1, vd = 0, cd = 0, on_p = 1, trip = 0;
  logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [11:0] vc = 0, ic = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_d, d;
  logic aw_y, w_y, b_v, ar_y, r_v, sw_on;
  logic [1:0] b_rs, r_rs, rs;
  int n_errors = 0, n_tests = 0, k, m, p, v, i, e;
  int md[3] = '{5, 1, 4};
  int q[$];
  hsm_if bus_if();
  hsm_device hsm_device_i(.clk_in, .sys_rst_in, .bus(bus_if),
    .on_pin_in(on_p), .analog_trip_in(trip), .volt_done_in(vd),
    .volt_code_in(vc), .curr_done_in(cd), .curr_code_in(ic),
    .volt_conv_out(), .curr_conv_out(), .divider_select_out(),
    .switch_on_out(sw_on));
  hsm_host hsm_host_i(.clk_in, .sys_rst_in, .bus(bus_if),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_y),
    .s_axi_awaddr_in(aw_a), .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_y),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_r), .s_axi_bresp_out(b_rs), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_y), .s_axi_araddr_in(ar_a), .s_axi_rvalid_out(r_v),
    .s_axi_rready_in(r_r), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs));
  hsm_sva hsm_sva_i(.clk_in, .sys_rst_in, .host_scl_in(bus_if.host_scl_o),
    .host_scl_oe_in(bus_if.host_scl_oe), .host_sda_in(bus_if.host_sda_o),
    .host_sda_oe_in(bus_if.host_sda_oe), .dev_sda_in(bus_if.dev_sda_o),
    .dev_sda_oe_in(bus_if.dev_sda_oe), .scl_in(bus_if.scl),
    .sda_in(bus_if.sda));
  initial forever #50 clk_in = ~clk_in;
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic lim();
    if (k >= 3000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    aw_a <= a;
    w_d <= x;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk_in);
      if (aw_y) aw_v <= 0;
      if (w_y) w_v <= 0;
      if (b_v) break;
    end
    lim();
    rs = b_rs;
    b_r <= 0;
    @(posedge clk_in);
  endtask
  task automatic axr(input logic [7:0] a);
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk_in);
      if (ar_y) ar_v <= 0;
      if (r_v) break;
    end
    lim();
    d = r_d;
    rs = r_rs;
    r_r <= 0;
    @(posedge clk_in);
  endtask
  // Bus frame: setup word, command word, then poll until idle
  task automatic run(input logic [31:0] x, input logic [31:0] c);
    int j;
    axw(hsm_pkg::HOST_WDATA_OFS, x);
    axw(hsm_pkg::HOST_CMD_OFS, c);
    for (j = 0; j < 3000; j++) begin
      axr(hsm_pkg::HOST_STAT_OFS);
      if (!d[0]) break;
    end
    k = j;
    lim();
  endtask
  task automatic rd(input int n, input logic [31:0] x);
    run(0, 32'h3 | (n << 2) | (n == 1) << 4);
    axr(hsm_pkg::HOST_RDATA_OFS);
    cmp(d & ((1 << 8 * n) - 1), x);
  endtask
  initial begin
    void'($urandom(32));
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 0;
    repeat (4) @(posedge clk_in);
    for (m = 0; m < 3; m++) begin
      run(md[m], 32'h5);
      v = 0;
      i = 0;
      for (p = 0; p < 2; p++) begin
        if (p) begin
          v = $urandom % 4096;
          i = $urandom % 4096;
          vc <= 12'(v);
          ic <= 12'(i);
          vd <= 1;
          cd <= 1;
          @(posedge clk_in);
          vd <= 0;
          cd <= 0;
        end
        q = '{v >> 4, i >> 4, v % 16 * 16 + i % 16};
        if (md[m] == 1) q = '{v >> 4, v % 16 * 16};
        if (md[m] == 4) q = '{i >> 4, i % 16 * 16};
        e = 0;
        foreach (q[j]) e = e * 256 + q[j];
        rd(q.size(), e);
      end
    end
    run(32'h0D81, 32'h9);
    run(32'h40, 32'h5);
    for (p = 1; p >= 0; p--) begin
      run(32'h83 | p << 8, 32'h9);
      cmp(sw_on, !p);
      rd(1, 32'h20 | p << 4);
    end
    trip <= 1;
    rd(1, 32'h2C);
    cmp(sw_on, 0);
    trip <= 0;
    on_p <= 0;
    rd(1, 32'h38);
    cmp(sw_on, 0);
    on_p <= 1;
    run(32'h0082, 32'h9);
    repeat (3) begin
      ic <= 12'hFFF;
      cd <= 1;
      @(posedge clk_in);
      cd <= 0;
      @(posedge clk_in);
    end
    rd(1, 32'h2B);
    run(32'h1D81, 32'h9);
    rd(1, 32'h01);
    run(32'h02, 32'h5);
    run(0, 32'h7);
    cmp(d[1], 1);
    axr(8'h10);
    cmp(rs, hsm_pkg::RESP_SLVERR);
    tally_and_finish();
  end
endmodule
`default_nettype wire
